// ===== clsgr_regs.sv
// clsgr_regs: codec control logic - serial instructions, interface latch,
// transmit/receive slot and port assignment, transmit gain code.
// assumes: all pins asynchronous to clk; bclk far slower than clk.
`timescale 1ns/10ps
// Notes on behaviour
// - after reset all latch pins are inputs
// - each latch pin direction set independently
// - direction byte bit7 is pin0, bits1-0 ignored
// - output pin drives its written data bit
// - input pin samples the external level
// - latch read returns sensed or programmed levels
// - data byte bit7 is pin0, bits1-0 ignored
// - reset gives nondelayed timing, slot at sync
// - slot assignment needs delayed timing and frames
// - tx and rx syncs may differ in phase
// - counters locate 8-bit slot from frame marker
// - low six bits give slot 0 to 63
// - new assignment applies on second frame
// - bit7 enables the selected pcm port
// - bit6 picks port, delayed timing only
// - gain code steps 0.1 dB, -0.4 to 19.0
// - instruction bits travel msb first
// - first byte bit7 is power down flag
module clsgr_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cclk,
  input  wire logic       cs_n,
  input  wire logic       ci,
  output logic            co_o,
  output logic            co_oe,
  input  wire logic [5:0] aux_io_pin_i,
  output logic      [5:0] aux_io_pin_o,
  output logic      [5:0] aux_io_pin_oe,
  input  wire logic       bclk,
  input  wire logic       tx_frame_sync,
  input  wire logic       rx_frame_sync,
  output logic            pcm_out_port0_o,
  output logic            pcm_out_port0_oe,
  output logic            pcm_out_port1_o,
  output logic            pcm_out_port1_oe,
  input  wire logic       pcm_in_port0,
  input  wire logic       pcm_in_port1,
  input  wire logic [7:0] tx_pcm_word,
  output logic            tx_pcm_take,
  output logic      [7:0] rx_pcm_word,
  output logic            rx_pcm_valid,
  output logic            power_down,
  output logic            delayed_timing,
  output logic      [7:0] encoder_gain_code
);

  function automatic logic [7:0] pins_to_byte(input logic [5:0] p);
    pins_to_byte = {p[0], p[1], p[2], p[3], p[4], p[5], 2'b00};
  endfunction : pins_to_byte

  function automatic logic [5:0] byte_to_pins(input logic [7:0] b);
    byte_to_pins = {b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction : byte_to_pins

  // pin synchroniser: aux[13:8] cclk cs_n ci bclk fsx fsr din0 din1
  logic [13:0] pin_raw;
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;
  logic        bclk_prev_q;

  assign pin_raw = {aux_io_pin_i, cclk, cs_n, ci, bclk, tx_frame_sync,
                    rx_frame_sync, pcm_in_port0, pcm_in_port1};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= clsgr_pkg::SYNC_RST;
      sync2_q <= clsgr_pkg::SYNC_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [5:0] pin_s    = sync2_q[13:8];
  wire       bclk_s   = sync2_q[4];
  wire       fsx_s    = sync2_q[3];
  wire       fsr_s    = sync2_q[2];
  wire       din0_s   = sync2_q[1];
  wire       din1_s   = sync2_q[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) bclk_prev_q <= 1'b0;
    else bclk_prev_q <= bclk_s;
  end

  wire bclk_rise = bclk_s & ~bclk_prev_q;
  wire bclk_fall = ~bclk_s & bclk_prev_q;

  // instruction decode
  logic                     pdn_stb;
  logic                     pdn_bit;
  logic                     cmd_stb;
  clsgr_pkg::clsgr_cmd_type cmd;
  logic [3:0]               hdr_addr;
  logic [7:0]               rd_byte;

  clsgr_serial u_serial (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .cclk_lvl (sync2_q[7]),
    .cs_n_lvl (sync2_q[6]),
    .ci_lvl   (sync2_q[5]),
    .rd_byte  (rd_byte),
    .hdr_addr (hdr_addr),
    .pdn_stb  (pdn_stb),
    .pdn_bit  (pdn_bit),
    .cmd_stb  (cmd_stb),
    .cmd      (cmd),
    .co_o     (co_o),
    .co_oe    (co_oe)
  );

  wire wr = cmd_stb & ~cmd.rd;

  logic [7:0] ctrl_q;
  logic [5:0] dir_q;
  logic [5:0] val_q;
  logic [7:0] gain_q;
  logic       pdn_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) pdn_q <= clsgr_pkg::PDN_RST;
    else if (pdn_stb) pdn_q <= pdn_bit;
  end

  // undefined address codes are dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= clsgr_pkg::CTRL_RST;
      dir_q  <= clsgr_pkg::DIR_RST;
      val_q  <= clsgr_pkg::VAL_RST;
      gain_q <= clsgr_pkg::GAIN_RST;
    end else if (wr) begin
      case (cmd.addr)
        clsgr_pkg::ADDR_CTRL:   ctrl_q <= cmd.data;
        clsgr_pkg::ADDR_LATCH:  val_q  <= byte_to_pins(cmd.data);
        clsgr_pkg::ADDR_DIR:    dir_q  <= byte_to_pins(cmd.data);
        clsgr_pkg::ADDR_TXGAIN: gain_q <= cmd.data;
        default: ;
      endcase
    end
  end

  // outputs drive the data register, inputs float and are sensed
  assign aux_io_pin_o  = val_q;
  assign aux_io_pin_oe = dir_q;

  wire [7:0] latch_rd = pins_to_byte((dir_q & val_q) | (~dir_q & pin_s));

  // time slot logic for each direction
  clsgr_pkg::clsgr_slot_cfg_type tx_cfg;
  clsgr_pkg::clsgr_slot_cfg_type rx_cfg;
  logic       tx_active;
  logic       rx_active;
  logic [2:0] tx_bit;
  logic [2:0] rx_bit;
  logic       tx_port;
  logic       rx_port;
  wire        delayed = ~ctrl_q[clsgr_pkg::CTRL_BIT_DN];

  wire tx_wr = wr & (cmd.addr == clsgr_pkg::ADDR_TXSLOT);
  wire rx_wr = wr & (cmd.addr == clsgr_pkg::ADDR_RXSLOT);

  clsgr_slot u_tx_slot (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bclk_rise (bclk_rise),
    .fs_lvl    (fsx_s),
    .delayed   (delayed),
    .wr_stb    (tx_wr),
    .wr_cfg    (clsgr_pkg::clsgr_slot_cfg_type'(cmd.data)),
    .cfg       (tx_cfg),
    .active    (tx_active),
    .bit_idx   (tx_bit),
    .port      (tx_port)
  );

  clsgr_slot u_rx_slot (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bclk_rise (bclk_rise),
    .fs_lvl    (fsr_s),
    .delayed   (delayed),
    .wr_stb    (rx_wr),
    .wr_cfg    (clsgr_pkg::clsgr_slot_cfg_type'(cmd.data)),
    .cfg       (rx_cfg),
    .active    (rx_active),
    .bit_idx   (rx_bit),
    .port      (rx_port)
  );

  always_comb begin
    rd_byte = 8'h00;
    case (hdr_addr)
      clsgr_pkg::ADDR_CTRL:   rd_byte = ctrl_q;
      clsgr_pkg::ADDR_LATCH:  rd_byte = latch_rd;
      clsgr_pkg::ADDR_DIR:    rd_byte = pins_to_byte(dir_q);
      clsgr_pkg::ADDR_TXGAIN: rd_byte = gain_q;
      clsgr_pkg::ADDR_RXSLOT: rd_byte = rx_cfg;
      clsgr_pkg::ADDR_TXSLOT: rd_byte = tx_cfg;
      default:                rd_byte = 8'h00;
    endcase
  end

  // transmit: act one clk after the slot counter moved
  logic       tick_q;
  logic [7:0] tx_sh_q;
  logic       tx_oe_q;
  logic       tx_port_q;
  logic       tx_take_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_q    <= 1'b0;
      tx_sh_q   <= 8'h00;
      tx_oe_q   <= 1'b0;
      tx_port_q <= 1'b0;
      tx_take_q <= 1'b0;
    end else begin
      tick_q    <= bclk_rise;
      tx_take_q <= 1'b0;
      if (tick_q) begin
        tx_oe_q   <= tx_active;
        tx_port_q <= tx_port;
        if (tx_active && tx_bit == 3'd0) begin
          tx_sh_q   <= tx_pcm_word;
          tx_take_q <= 1'b1;
        end else if (tx_active) begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  wire tx_ok = tx_oe_q & ~pdn_q & (gain_q != 8'h00);

  assign pcm_out_port0_o  = tx_sh_q[7];
  assign pcm_out_port1_o  = tx_sh_q[7];
  assign pcm_out_port0_oe = tx_ok & ~tx_port_q;
  assign pcm_out_port1_oe = tx_ok & tx_port_q;
  assign tx_pcm_take      = tx_take_q;

  // receive: sample the chosen port on falling bclk
  logic [6:0] rx_sh_q;
  logic [7:0] rx_word_q;
  logic       rx_valid_q;
  wire        rx_din = rx_port ? din1_s : din0_s;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sh_q    <= 7'h00;
      rx_word_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (bclk_fall && rx_active && !pdn_q) begin
        rx_sh_q <= {rx_sh_q[5:0], rx_din};
        if (rx_bit == 3'd7) begin
          rx_word_q  <= {rx_sh_q, rx_din};
          rx_valid_q <= 1'b1;
        end
      end
    end
  end

  assign rx_pcm_word       = rx_word_q;
  assign rx_pcm_valid      = rx_valid_q;
  assign power_down        = pdn_q;
  assign delayed_timing    = delayed;
  assign encoder_gain_code = gain_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_latch_reset_in:
  assert property ($fell(sys_rst) |-> aux_io_pin_oe == 6'h00)
    else $error("latch pins driven after reset");

  a_dir_write_map:
  assert property (wr && cmd.addr == clsgr_pkg::ADDR_DIR
                   |=> aux_io_pin_oe == byte_to_pins($past(cmd.data)))
    else $error("direction write not mapped");

  a_val_write_map:
  assert property (wr && cmd.addr == clsgr_pkg::ADDR_LATCH
                   |=> aux_io_pin_o == byte_to_pins($past(cmd.data)))
    else $error("latch data write not mapped");

  a_input_readback:
  assert property (dir_q == 6'h00 |-> latch_rd == pins_to_byte(pin_s))
    else $error("input pin readback wrong");

  a_reset_nondelay:
  assert property ($fell(sys_rst) |-> !delayed_timing)
    else $error("not nondelayed after reset");

  a_slot_not_early:
  assert property (tx_wr |=> tx_cfg == $past(tx_cfg))
    else $error("slot assignment applied at once");

  a_port1_delayed:
  assert property (pcm_out_port1_oe |-> $past(delayed, 2))
    else $error("port 1 used without delayed timing");

  a_ports_exclusive:
  assert property (!(pcm_out_port0_oe && pcm_out_port1_oe))
    else $error("both pcm outputs driven");

  a_gain_mute:
  assert property (gain_q == 8'h00 |-> !pcm_out_port0_oe && !pcm_out_port1_oe)
    else $error("output with zero gain code");

  a_power_flag:
  assert property (pdn_stb |=> power_down == $past(pdn_bit))
    else $error("power flag not taken");

  a_rx_slot_bits:
  assert property (rx_valid_q |-> $past(rx_bit) == 3'd7 && $past(rx_active))
    else $error("rx word not at slot end");

  a_take_at_bit0:
  assert property (tx_pcm_take |-> $past(tx_active) && $past(tx_bit) == 3'd0)
    else $error("tx word taken away from slot bit 0");

  a_gain_write_map:
  assert property (wr && cmd.addr == clsgr_pkg::ADDR_TXGAIN |=> encoder_gain_code == $past(cmd.data))
    else $error("gain write not taken");

  a_ctrl_timing_mode:
  assert property (wr && cmd.addr == clsgr_pkg::ADDR_CTRL
                   |=> delayed_timing == !$past(cmd.data[clsgr_pkg::CTRL_BIT_DN]))
    else $error("timing mode not taken from control write");

  c_dir_write: cover property (wr && cmd.addr == clsgr_pkg::ADDR_DIR);
  c_tx_port1:  cover property ($rose(pcm_out_port1_oe));
  c_rx_word:   cover property (rx_valid_q && delayed);
  c_co_read:   cover property ($rose(co_oe));
  c_rx_port1:  cover property (rx_valid_q && rx_port);

endmodule : clsgr_regs

// ===== clsgr_pkg.sv
// clsgr_pkg: constants and carriers shared by the codec register logic.
// assumes: one- or two-byte serial instructions, six latch pins, 64-slot frames.
package clsgr_pkg;

  localparam int BYTE_BITS   = 8;
  localparam int LATCH_PINS  = 6;
  localparam int SLOT_CNT_W  = 9;
  localparam int FRAME_APPLY = 2;

  // first instruction byte fields
  localparam int HDR_BIT_PDN = 7;
  localparam int HDR_ADDR_HI = 6;
  localparam int HDR_ADDR_LO = 3;
  localparam int HDR_BIT_RD  = 2;
  localparam int HDR_BIT_P2  = 1;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_LATCH  = 4'h1;
  localparam logic [3:0] ADDR_DIR    = 4'h2;
  localparam logic [3:0] ADDR_TXGAIN = 4'h5;
  localparam logic [3:0] ADDR_RXSLOT = 4'h9;
  localparam logic [3:0] ADDR_TXSLOT = 4'ha;

  localparam int CTRL_BIT_DN = 3;

  localparam logic [7:0]  CTRL_RST   = 8'h89;
  localparam logic [5:0]  DIR_RST    = 6'h00;
  localparam logic [5:0]  VAL_RST    = 6'h00;
  localparam logic [7:0]  GAIN_RST   = 8'hbf;
  localparam logic [7:0]  SLOT_RST   = 8'h80;
  localparam logic        PDN_RST    = 1'b1;
  localparam logic [13:0] SYNC_RST   = 14'h0040;

  typedef struct packed {
    logic       pdn;
    logic [3:0] addr;
    logic       rd;
    logic [7:0] data;
  } clsgr_cmd_type;

  typedef struct packed {
    logic       en;
    logic       port;
    logic [5:0] slot;
  } clsgr_slot_cfg_type;

endpackage : clsgr_pkg

// ===== clsgr_serial.sv
// clsgr_serial: serial control port, one byte per chip-select low period.
// assumes: inputs already synchronised to clk; msb first on ci and co.
`timescale 1ns/10ps
module clsgr_serial (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    cclk_lvl,
  input  wire logic                    cs_n_lvl,
  input  wire logic                    ci_lvl,
  input  wire logic [7:0]              rd_byte,
  output logic      [3:0]              hdr_addr,
  output logic                         pdn_stb,
  output logic                         pdn_bit,
  output logic                         cmd_stb,
  output clsgr_pkg::clsgr_cmd_type     cmd,
  output logic                         co_o,
  output logic                         co_oe
);
  logic       cclk_prev_q;
  logic       cs_prev_q;
  logic [7:0] sh_q;
  logic [7:0] hdr_q;
  logic [7:0] out_q;
  logic [3:0] cnt_q;
  logic       second_q;
  logic       load_q;

  wire cclk_rise = cclk_lvl & ~cclk_prev_q;
  wire cclk_fall = ~cclk_lvl & cclk_prev_q;
  wire cs_end    = cs_n_lvl & ~cs_prev_q;
  wire byte_ok   = cnt_q == 4'(clsgr_pkg::BYTE_BITS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      cclk_prev_q <= cclk_lvl;
      cs_prev_q   <= cs_n_lvl;
    end
  end

  // bit 7 arrives first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_q  <= 8'h00;
      cnt_q <= 4'h0;
    end else if (cs_end) begin
      cnt_q <= 4'h0;
    end else if (!cs_n_lvl && cclk_rise) begin
      sh_q <= {sh_q[6:0], ci_lvl};
      if (!byte_ok) cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_q    <= 8'h00;
      second_q <= 1'b0;
      pdn_stb  <= 1'b0;
      pdn_bit  <= 1'b0;
      load_q   <= 1'b0;
      cmd_stb  <= 1'b0;
      cmd      <= '0;
    end else begin
      pdn_stb <= 1'b0;
      cmd_stb <= 1'b0;
      load_q  <= 1'b0;
      if (cs_end && !second_q && byte_ok) begin
        hdr_q    <= sh_q;
        pdn_stb  <= 1'b1;
        pdn_bit  <= sh_q[clsgr_pkg::HDR_BIT_PDN];
        second_q <= sh_q[clsgr_pkg::HDR_BIT_P2];
        load_q   <= sh_q[clsgr_pkg::HDR_BIT_P2] & sh_q[clsgr_pkg::HDR_BIT_RD];
      end else if (cs_end) begin
        second_q <= 1'b0;
        cmd_stb  <= second_q & byte_ok;
        cmd      <= '{pdn: hdr_q[clsgr_pkg::HDR_BIT_PDN],
                      addr: hdr_q[clsgr_pkg::HDR_ADDR_HI:clsgr_pkg::HDR_ADDR_LO],
                      rd: hdr_q[clsgr_pkg::HDR_BIT_RD], data: sh_q};
      end
    end
  end

  // read data shifts out on falling cclk, bit 7 first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) out_q <= 8'h00;
    else if (load_q) out_q <= rd_byte;
    else if (!cs_n_lvl && cclk_fall && second_q) out_q <= {out_q[6:0], 1'b0};
  end

  assign hdr_addr = hdr_q[clsgr_pkg::HDR_ADDR_HI:clsgr_pkg::HDR_ADDR_LO];
  assign co_o     = out_q[7];
  assign co_oe    = ~cs_n_lvl & second_q & hdr_q[clsgr_pkg::HDR_BIT_RD];

endmodule : clsgr_serial

// ===== clsgr_slot.sv
// clsgr_slot: frame marker, slot counter and slot/port assignment of one
// direction. assumes: bclk_rise and fs_lvl come from synchronised pins.
`timescale 1ns/10ps
module clsgr_slot (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         bclk_rise,
  input  wire logic                         fs_lvl,
  input  wire logic                         delayed,
  input  wire logic                         wr_stb,
  input  wire clsgr_pkg::clsgr_slot_cfg_type wr_cfg,
  output clsgr_pkg::clsgr_slot_cfg_type     cfg,
  output logic                              active,
  output logic [2:0]                        bit_idx,
  output logic                              port
);
  localparam int CW = clsgr_pkg::SLOT_CNT_W;

  clsgr_pkg::clsgr_slot_cfg_type pend_q;
  logic          pend_v_q;
  logic [1:0]    fcnt_q;
  logic          fs_prev_q;
  logic          live_q;
  logic          pre_q;
  logic [CW-1:0] cnt_q;

  wire marker = bclk_rise & fs_lvl & ~fs_prev_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) fs_prev_q <= 1'b0;
    else if (bclk_rise) fs_prev_q <= fs_lvl;
  end

  // new assignment waits for the second marker after the write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg      <= clsgr_pkg::clsgr_slot_cfg_type'(clsgr_pkg::SLOT_RST);
      pend_q   <= '0;
      pend_v_q <= 1'b0;
      fcnt_q   <= 2'd0;
    end else if (wr_stb) begin
      pend_q   <= wr_cfg;
      pend_v_q <= 1'b1;
      fcnt_q   <= 2'd0;
    end else if (marker && pend_v_q) begin
      if (fcnt_q == 2'(clsgr_pkg::FRAME_APPLY - 1)) begin
        cfg      <= pend_q;
        pend_v_q <= 1'b0;
      end
      fcnt_q <= fcnt_q + 2'd1;
    end
  end

  // delayed timing inserts one bit period after the marker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_q <= 1'b0;
      pre_q  <= 1'b0;
      cnt_q  <= '0;
    end else if (marker) begin
      live_q <= 1'b1;
      pre_q  <= delayed;
      cnt_q  <= '0;
    end else if (bclk_rise && live_q) begin
      if (pre_q) pre_q <= 1'b0;
      else if (&cnt_q) live_q <= 1'b0;
      else cnt_q <= cnt_q + 1'b1;
    end
  end

  wire [5:0] eff_slot = delayed ? cfg.slot : 6'h00;
  assign port    = delayed & cfg.port;
  assign bit_idx = cnt_q[2:0];
  assign active  = live_q & ~pre_q & cfg.en & (cnt_q[CW-1:3] == eff_slot);

endmodule : clsgr_slot

// ===== clsgr_host_model.sv
// clsgr_host_model: serial control port master and tdm backplane partner.
// assumes: co is resolved with a pull-up; bclk free-running, 64 bits a frame.
`timescale 1ns/10ps
module clsgr_host_model (
  input  wire logic       clk,
  input  wire logic       co,
  input  wire logic [7:0] rx_word,
  output logic            cclk,
  output logic            cs_n,
  output logic            ci,
  output logic            bclk,
  output logic            tx_frame_sync,
  output logic            rx_frame_sync,
  output logic            pcm_in_port0,
  output logic            pcm_in_port1,
  output logic [5:0]      bit_cnt
);
  initial begin
    {cclk, ci, bclk, tx_frame_sync, rx_frame_sync, pcm_in_port0, pcm_in_port1} = 7'h00;
    cs_n    = 1'b1;
    bit_cnt = 6'h00;
  end

  // offset keeps bclk edges away from clk edges
  initial begin
    #1;
    forever #62.5 bclk = ~bclk;
  end

  // tx marker at count 0, rx marker at count 32
  always @(negedge bclk) begin
    tx_frame_sync = (bit_cnt == 6'h3f);
    rx_frame_sync = (bit_cnt == 6'h1f);
  end

  // rx slot 2 carries rx_word on port0 and its inverse on port1; idle lines toggle
  always @(posedge bclk) begin
    bit_cnt = bit_cnt + 6'h01;
    if (bit_cnt >= 6'h31 && bit_cnt <= 6'h38) begin
      pcm_in_port0 = rx_word[6'h38 - bit_cnt];
      pcm_in_port1 = ~pcm_in_port0;
    end else begin
      pcm_in_port0 = ~pcm_in_port0;
      pcm_in_port1 = ~pcm_in_port1;
    end
  end

  // one byte in its own chip-select period
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      ci = b[i];
      #50 cclk = 1'b1;
      r[i] = co;
      #50 cclk = 1'b0;
    end
    #50 cs_n = 1'b1;
    ci = ~ci;
    #100;
  endtask : xfer
endmodule : clsgr_host_model

// ===== clsgr_regs_tb_top.sv
// clsgr_regs_tb_top: self-checking bench for the codec register logic.
// assumes: clsgr_host_model plays the host and the pcm backplane.
`timescale 1ns/10ps
module clsgr_regs_tb_top;
  logic       clk, sys_rst, cclk, cs_n, ci, co_o, co_oe, co_pin, bclk, tx_fs, rx_fs;
  logic       pi0, pi1, po0, po0_oe, po1, po1_oe, tx_pcm_take, rx_pcm_valid, power_down, delayed_timing;
  logic [5:0] pin_i, pin_o, pin_oe, bit_cnt;
  logic [7:0] rx_pcm_word, gain, rv;
  logic [7:0] tx_word = 8'hc6;
  int         failures, checks, takes;

  assign co_pin = co_oe ? co_o : 1'b1;
  assign pin_i  = (pin_oe & pin_o) | (~pin_oe & 6'h2a);

  always #2.5 clk = ~clk;

  always @(negedge clk) if (tx_pcm_take === 1'b1) takes++;

  clsgr_regs i_clsgr_regs (.clk(clk), .sys_rst(sys_rst), .cclk(cclk), .cs_n(cs_n), .ci(ci),
    .co_o(co_o), .co_oe(co_oe), .aux_io_pin_i(pin_i), .aux_io_pin_o(pin_o), .aux_io_pin_oe(pin_oe),
    .bclk(bclk), .tx_frame_sync(tx_fs), .rx_frame_sync(rx_fs), .pcm_out_port0_o(po0),
    .pcm_out_port0_oe(po0_oe), .pcm_out_port1_o(po1), .pcm_out_port1_oe(po1_oe),
    .pcm_in_port0(pi0), .pcm_in_port1(pi1), .tx_pcm_word(tx_word), .tx_pcm_take(tx_pcm_take),
    .rx_pcm_word(rx_pcm_word), .rx_pcm_valid(rx_pcm_valid), .power_down(power_down),
    .delayed_timing(delayed_timing), .encoder_gain_code(gain));

  clsgr_host_model i_clsgr_host_model (.clk(clk), .co(co_pin), .rx_word(8'h5b), .cclk(cclk),
    .cs_n(cs_n), .ci(ci), .bclk(bclk), .tx_frame_sync(tx_fs), .rx_frame_sync(rx_fs),
    .pcm_in_port0(pi0), .pcm_in_port1(pi1), .bit_cnt(bit_cnt));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_clsgr_host_model.xfer({1'b0, a, 3'b010}, r);
    i_clsgr_host_model.xfer(d, r);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    logic [7:0] r;
    i_clsgr_host_model.xfer({1'b0, a, 3'b110}, r);
    i_clsgr_host_model.xfer(8'h00, d);
  endtask : reg_rd

  // start just after a tx marker so a write never straddles one
  task automatic align();
    @(negedge bclk);
    while (bit_cnt !== 6'h02) @(negedge bclk);
  endtask : align

  // one tx frame: first driven bit index, bit count, drive seen on the other port, word
  task automatic fchk(input logic p, input int ef, input int en);
    int         f;
    int         n;
    int         o;
    int         t;
    logic [7:0] w;
    f = -1;
    n = 0;
    o = 0;
    w = 8'h00;
    while (bit_cnt !== 6'h3f || bclk !== 1'b0) @(negedge bclk);
    t = takes;
    repeat (64) begin
      @(negedge bclk);
      if ((p ? po1_oe : po0_oe) === 1'b1) begin
        if (f < 0) f = bit_cnt;
        n++;
        w = {w[6:0], p ? po1 : po0};
      end
      if ((p ? po0_oe : po1_oe) === 1'b1) o++;
    end
    chk("slot start", 8'(f), 8'(ef));
    chk("slot bits", 8'(n), 8'(en));
    chk("other port drive", 8'(o), 8'h00);
    if (en > 0) chk("tx word", w, tx_word);
    if (en > 0) chk("tx take", 8'(takes - t), 8'h01);
  endtask : fchk

  task automatic rxchk(input logic [7:0] exp);
    int k;
    repeat (192) @(posedge bclk);
    for (k = 0; k < 4000 && rx_pcm_valid !== 1'b1; k++) @(negedge clk);
    chk("rx valid", {7'h00, rx_pcm_valid}, 8'h01);
    chk("rx word", rx_pcm_word, exp);
  endtask : rxchk

  initial begin
    #400000;
    failures++;
    test_done();
  end

  initial begin
    clk      = 1'b0;
    sys_rst  = 1'b1;
    failures = 0;
    checks   = 0;
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("oe after reset", {2'b00, pin_oe}, 8'h00);
    chk("gain after reset", gain, 8'hbf);
    chk("delayed after reset", {7'h00, delayed_timing}, 8'h00);
    i_clsgr_host_model.xfer(8'h00, rv);
    chk("power up", {7'h00, power_down}, 8'h00);
    i_clsgr_host_model.xfer(8'h80, rv);
    chk("power down", {7'h00, power_down}, 8'h01);
    i_clsgr_host_model.xfer(8'h00, rv);
    reg_rd(clsgr_pkg::ADDR_LATCH, rv);
    chk("latch all inputs", rv, 8'h54);
    reg_wr(clsgr_pkg::ADDR_LATCH, 8'hab);
    reg_wr(clsgr_pkg::ADDR_DIR, 8'hc3);
    chk("pin oe", {2'b00, pin_oe}, 8'h03);
    chk("pin out", {2'b00, pin_o}, 8'h15);
    reg_rd(clsgr_pkg::ADDR_LATCH, rv);
    chk("latch read", rv, 8'h94);
    reg_rd(clsgr_pkg::ADDR_DIR, rv);
    chk("dir read", rv, 8'hc0);
    reg_wr(clsgr_pkg::ADDR_TXGAIN, 8'hc3);
    reg_rd(clsgr_pkg::ADDR_TXGAIN, rv);
    chk("gain read", rv, 8'hc3);
    chk("gain port", gain, 8'hc3);
    reg_rd(4'h4, rv);
    chk("unmapped read", rv, 8'h00);
    fchk(1'b0, 0, 8);
    reg_wr(clsgr_pkg::ADDR_CTRL, 8'h81);
    chk("delayed mode", {7'h00, delayed_timing}, 8'h01);
    align();
    reg_wr(clsgr_pkg::ADDR_TXSLOT, 8'h83);
    fchk(1'b0, 1, 8);
    fchk(1'b0, 25, 8);
    align();
    reg_wr(clsgr_pkg::ADDR_TXSLOT, 8'hc5);
    fchk(1'b0, 25, 8);
    fchk(1'b1, 41, 8);
    reg_wr(clsgr_pkg::ADDR_TXGAIN, 8'h00);
    fchk(1'b1, -1, 0);
    reg_wr(clsgr_pkg::ADDR_TXGAIN, 8'hbf);
    align();
    reg_wr(clsgr_pkg::ADDR_TXSLOT, 8'h45);
    repeat (64) @(posedge bclk);
    fchk(1'b1, -1, 0);
    reg_wr(clsgr_pkg::ADDR_RXSLOT, 8'h82);
    rxchk(8'h5b);
    reg_wr(clsgr_pkg::ADDR_RXSLOT, 8'hc2);
    rxchk(8'ha4);
    test_done();
  end
endmodule : clsgr_regs_tb_top
